/* rtl/servo_fault_defines.vh */
// constants for the servo motion fault monitor
`ifndef SERVO_FAULT_DEFINES_VH
`define SERVO_FAULT_DEFINES_VH
// register byte offsets
`define ADR_CTRL        8'h00
`define ADR_LIMSEL      8'h04
`define ADR_OVSPD       8'h08
`define ADR_RATED       8'h0c
`define ADR_POSERR      8'h10
`define ADR_SOFTLO      8'h14
`define ADR_SOFTHI      8'h18
`define ADR_OVLPCT      8'h1c
`define ADR_STATUS      8'h20
`define ADR_MASK        8'h24
`define ADR_CODE        8'h28
`define ADR_UNLOCK      8'h2c
`define ADR_ZOFFS       8'h30
`define ADR_MAP0        8'h40
// ctrl fields
`define CTRL_HOMESW     0
`define CTRL_FIXLEN     1
`define CTRL_CLEAR      2
// limit select fields
`define LIM_SOFT        0
`define LIM_HARD        1
// input function numbers
`define FN_HOME         8'h22
`define FN_FIXLEN       8'h28
// fault codes
`define CODE_NOHOME     16'h00c8
`define CODE_DUPMAP     16'h00c9
`define CODE_OVSPD      16'h00ca
`define CODE_POSERR     16'h00cb
`define CODE_NOFIX      16'h00cc
`define CODE_NOHOMING   16'h00cd
`define CODE_OVLOAD     16'h00ce
`define CODE_SOFTLIM    16'h00cf
`define CODE_HARDLIM    16'h00d0
`define CODE_PLANFAIL   16'h00d1
`define UNLOCK_KEY      16'h20e5
`define PCT_FULL        32'h00000064
// reset values
`define RST_OVSPD       16'h0078
`define RST_RATED       16'h0bb8
`define RST_POSERR      32'h00010000
`define RST_OVLPCT      16'h0064
`define RST_SOFTLO      32'h80000000
`define RST_SOFTHI      32'h7fffffff
// unassigned terminal and no-fault values
`define FN_NONE         8'h00
`define CODE_NONE       16'h0000
`define FAULT_BITS      10
`endif

/* rtl/servo_motion_fault_monitor.v */
// servo motion fault monitor with wishbone registers
`timescale 1ns/1ps
`include "servo_fault_defines.vh"
module servo_motion_fault_monitor #(
  parameter NTERM        = 8,
  parameter OVL_CYCLES   = 32'd100000
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // motion state, same clock
  input  wire signed [31:0] speedAct,
  input  wire signed [31:0] posCmd,
  input  wire signed [31:0] posAct,
  input  wire signed [31:0] userPos,
  input  wire [15:0] currentPct,
  input  wire        absMoveTrig,
  input  wire        homingDone,
  input  wire        planFail,
  // limit switch pins
  input  wire        fwdLimitPin,
  input  wire        revLimitPin,
  // outputs
  output reg  [15:0] faultCode_q,
  output wire        faultActive,
  output wire        irq
);
  // pin synchronisers
  reg [1:0] fwdSync_q;
  reg [1:0] revSync_q;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      fwdSync_q <= 2'h0;
      revSync_q <= 2'h0;
    end else begin
      fwdSync_q <= {fwdSync_q[0], fwdLimitPin};
      revSync_q <= {revSync_q[0], revLimitPin};
    end
  end
  wire fwdLim = fwdSync_q[1];
  wire revLim = revSync_q[1];

  // registers
  reg  [1:0]  ctrl_q;
  reg  [1:0]  limSel_q;
  reg  [15:0] ovSpd_q;
  reg  [15:0] rated_q;
  reg  [31:0] posErrLim_q;
  reg  signed [31:0] softLo_q;
  reg  signed [31:0] softHi_q;
  reg  [15:0] ovlPct_q;
  reg  [`FAULT_BITS-1:0] status_q;
  reg  [`FAULT_BITS-1:0] mask_q;
  reg  [15:0] unlock_q;
  reg  [31:0] zOffs_q;
  reg  [7:0]  termMap_q [0:NTERM-1];
  reg         faultActive_q;
  reg         irq_q;

  wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wbWr  = wbReq & wb_we_i & (&wb_sel_i);

  // per-register write strobes
  wire wrCtrl   = wbWr & (wb_adr_i == `ADR_CTRL);
  wire wrLimSel = wbWr & (wb_adr_i == `ADR_LIMSEL);
  wire wrOvSpd  = wbWr & (wb_adr_i == `ADR_OVSPD);
  wire wrRated  = wbWr & (wb_adr_i == `ADR_RATED);
  wire wrPosErr = wbWr & (wb_adr_i == `ADR_POSERR);
  wire wrSoftLo = wbWr & (wb_adr_i == `ADR_SOFTLO);
  wire wrSoftHi = wbWr & (wb_adr_i == `ADR_SOFTHI);
  wire wrOvlPct = wbWr & (wb_adr_i == `ADR_OVLPCT);
  wire wrStatus = wbWr & (wb_adr_i == `ADR_STATUS);
  wire wrMask   = wbWr & (wb_adr_i == `ADR_MASK);
  wire wrUnlock = wbWr & (wb_adr_i == `ADR_UNLOCK);
  wire wrZOffs  = wbWr & (wb_adr_i == `ADR_ZOFFS);
  wire clearPulse = wrCtrl & wb_dat_i[`CTRL_CLEAR];
  wire [NTERM-1:0] mapSel;

  // terminal map checks, one slice per terminal
  wire [NTERM-1:0] homeHit;
  wire [NTERM-1:0] fixHit;
  wire [NTERM-1:0] dupHit;
  genvar t;
  genvar u;
  generate
    for (t = 0; t < NTERM; t = t + 1) begin : gChk
      wire [NTERM-1:0] sameFn;
      assign homeHit[t] = termMap_q[t] == `FN_HOME;
      assign fixHit[t]  = termMap_q[t] == `FN_FIXLEN;
      // unassigned entries may repeat freely
      for (u = 0; u < NTERM; u = u + 1) begin : gPair
        if (u > t) begin : gCmp
          assign sameFn[u] = (termMap_q[t] != `FN_NONE) &&
                             (termMap_q[t] == termMap_q[u]);
        end else begin : gSkip
          assign sameFn[u] = 1'b0;
        end
      end
      assign dupHit[t] = |sameFn;
    end
  endgenerate
  wire homeMapped = |homeHit;
  wire fixMapped  = |fixHit;
  wire dupMapped  = |dupHit;

  // speed and position checks
  wire [31:0] speedMag = speedAct[31] ? (~speedAct + 32'h1) : speedAct;
  wire [63:0] speedScaled = {32'h0, speedMag} * {32'h0, `PCT_FULL};
  wire [63:0] speedLimit  = {48'h0, ovSpd_q} * {48'h0, rated_q};
  wire signed [32:0] posDiff = {posCmd[31], posCmd} - {posAct[31], posAct};
  wire [32:0] posDiffMag = posDiff[32] ? (~posDiff + 33'h1) : posDiff;
  wire spdNeg = speedAct[31];
  wire spdPos = ~speedAct[31] & (speedAct != 32'h0);

  // overload timer
  reg [31:0] ovlCnt_q;
  wire overCur = currentPct > ovlPct_q;
  always @(posedge ref_clk) begin
    if (!nrst)
      ovlCnt_q <= 32'h0;
    else if (!overCur)
      ovlCnt_q <= 32'h0;
    else if (ovlCnt_q < OVL_CYCLES)
      ovlCnt_q <= ovlCnt_q + 32'h1;
  end

  // wide products registered, kept off the fault latch path
  reg overSpeed_q;
  reg overPosErr_q;
  always @(posedge ref_clk) begin
    if (!nrst) begin
      overSpeed_q  <= 1'b0;
      overPosErr_q <= 1'b0;
    end else begin
      overSpeed_q  <= speedScaled > speedLimit;
      overPosErr_q <= posDiffMag > {1'b0, posErrLim_q};
    end
  end

  // fault conditions, bit order follows code order
  wire [`FAULT_BITS-1:0] cond;
  assign cond[0] = ctrl_q[`CTRL_HOMESW] & ~homeMapped;
  assign cond[1] = dupMapped;
  assign cond[2] = overSpeed_q;
  assign cond[3] = overPosErr_q;
  assign cond[4] = ctrl_q[`CTRL_FIXLEN] & ~fixMapped;
  assign cond[5] = absMoveTrig & ~homingDone;
  assign cond[6] = overCur & (ovlCnt_q >= OVL_CYCLES);
  assign cond[7] = limSel_q[`LIM_SOFT] &
                   ((userPos < softLo_q & spdNeg) |
                    (userPos > softHi_q & spdPos));
  assign cond[8] = limSel_q[`LIM_HARD] &
                   ((revLim & spdNeg) |
                    (fwdLim & spdPos));
  assign cond[9] = planFail;

  // first raised code, lowest number wins
  reg [15:0] newCode;
  always @* begin
    newCode = 16'h0;
    if (cond[9]) newCode = `CODE_PLANFAIL;
    if (cond[8]) newCode = `CODE_HARDLIM;
    if (cond[7]) newCode = `CODE_SOFTLIM;
    if (cond[6]) newCode = `CODE_OVLOAD;
    if (cond[5]) newCode = `CODE_NOHOMING;
    if (cond[4]) newCode = `CODE_NOFIX;
    if (cond[3]) newCode = `CODE_POSERR;
    if (cond[2]) newCode = `CODE_OVSPD;
    if (cond[1]) newCode = `CODE_DUPMAP;
    if (cond[0]) newCode = `CODE_NOHOME;
  end

  // latched fault code, next value shared with the active flag
  reg [15:0] faultCode_d;
  always @* begin
    faultCode_d = faultCode_q;
    if (faultCode_q == `CODE_NONE && |cond)
      faultCode_d = newCode;
    else if (clearPulse)
      faultCode_d = (|cond) ? newCode : `CODE_NONE;
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      faultCode_q   <= `CODE_NONE;
      faultActive_q <= 1'b0;
    end else begin
      faultCode_q   <= faultCode_d;
      faultActive_q <= faultCode_d != `CODE_NONE;
    end
  end
  assign faultActive = faultActive_q;

  // sticky status, set wins over a one-to-clear in the same cycle
  wire [`FAULT_BITS-1:0] status_d;
  wire [`FAULT_BITS-1:0] mask_d;
  genvar b;
  generate
    for (b = 0; b < `FAULT_BITS; b = b + 1) begin : gStat
      assign status_d[b] = cond[b] | (status_q[b] & ~(wrStatus & wb_dat_i[b]));
      assign mask_d[b]   = wrMask ? wb_dat_i[b] : mask_q[b];
    end
  endgenerate

  always @(posedge ref_clk) begin
    if (!nrst)
      status_q <= {`FAULT_BITS{1'b0}};
    else
      status_q <= status_d;
  end

  // irq from next status and mask, so it rises with the status bit
  always @(posedge ref_clk) begin
    if (!nrst)
      irq_q <= 1'b0;
    else
      irq_q <= |(status_d & mask_d);
  end
  assign irq = irq_q;

  // register writes
  genvar g;
  generate
    for (g = 0; g < NTERM; g = g + 1) begin : gMap
      assign mapSel[g] = wb_adr_i == (`ADR_MAP0 + g * 4);
      always @(posedge ref_clk) begin
        if (!nrst)
          termMap_q[g] <= `FN_NONE;
        else if (wbWr && mapSel[g])
          termMap_q[g] <= wb_dat_i[7:0];
      end
    end
  endgenerate

  // configuration registers, full-word writes only
  always @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_q      <= 2'h0;
      limSel_q    <= 2'h0;
      ovSpd_q     <= `RST_OVSPD;
      rated_q     <= `RST_RATED;
      posErrLim_q <= `RST_POSERR;
      softLo_q    <= `RST_SOFTLO;
      softHi_q    <= `RST_SOFTHI;
      ovlPct_q    <= `RST_OVLPCT;
      mask_q      <= {`FAULT_BITS{1'b0}};
    end else begin
      if (wrCtrl)
        ctrl_q <= wb_dat_i[1:0];
      if (wrLimSel)
        limSel_q <= wb_dat_i[1:0];
      if (wrOvSpd)
        ovSpd_q <= wb_dat_i[15:0];
      if (wrRated)
        rated_q <= wb_dat_i[15:0];
      if (wrPosErr)
        posErrLim_q <= wb_dat_i;
      if (wrSoftLo)
        softLo_q <= wb_dat_i;
      if (wrSoftHi)
        softHi_q <= wb_dat_i;
      if (wrOvlPct)
        ovlPct_q <= wb_dat_i[15:0];
      mask_q <= mask_d;
    end
  end

  // offset only taken while unlocked; any offset write spends the key
  always @(posedge ref_clk) begin
    if (!nrst) begin
      unlock_q <= 16'h0;
      zOffs_q  <= 32'h0;
    end else if (wrUnlock) begin
      unlock_q <= wb_dat_i[15:0];
    end else if (wrZOffs) begin
      if (unlock_q == `UNLOCK_KEY)
        zOffs_q <= wb_dat_i;
      unlock_q <= 16'h0;
    end
  end

  // read mux
  reg [31:0] rdData;
  integer    k;
  always @* begin
    rdData = 32'h0;
    case (wb_adr_i)
      `ADR_CTRL:   rdData = {30'h0, ctrl_q};
      `ADR_LIMSEL: rdData = {30'h0, limSel_q};
      `ADR_OVSPD:  rdData = {16'h0, ovSpd_q};
      `ADR_RATED:  rdData = {16'h0, rated_q};
      `ADR_POSERR: rdData = posErrLim_q;
      `ADR_SOFTLO: rdData = softLo_q;
      `ADR_SOFTHI: rdData = softHi_q;
      `ADR_OVLPCT: rdData = {16'h0, ovlPct_q};
      `ADR_STATUS: rdData = {{(32-`FAULT_BITS){1'b0}}, status_q};
      `ADR_MASK:   rdData = {{(32-`FAULT_BITS){1'b0}}, mask_q};
      `ADR_CODE:   rdData = {16'h0, faultCode_q};
      `ADR_UNLOCK: rdData = {31'h0, unlock_q == `UNLOCK_KEY};
      `ADR_ZOFFS:  rdData = zOffs_q;
      default: begin
        for (k = 0; k < NTERM; k = k + 1)
          if (mapSel[k])
            rdData = {24'h0, termMap_q[k]};
      end
    endcase
  end

  // single-wait ack
  always @(posedge ref_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbReq ? rdData : 32'h0;
    end
  end
endmodule // servo_motion_fault_monitor

/* verification/servo_fault_checker.sv */
// port assertions for the servo fault monitor
`timescale 1ns/1ps
`include "servo_fault_defines.vh"
module servo_fault_checker (
  // clock, reset and bus
  input wire        ref_clk,
  input wire        nrst,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [7:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  // motion and faults
  input wire        absMoveTrig,
  input wire        homingDone,
  input wire        planFail,
  input wire [15:0] faultCode_q,
  input wire        faultActive,
  input wire        irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire req    = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire clrReq = req & wb_we_i & (wb_sel_i == 4'hf) & (wb_adr_i == `ADR_CTRL) & wb_dat_i[2];
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a: assert property (req |=> wb_ack_o) else $error("ack missing");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not idle");
  code_held_a: assert property (faultActive && !clrReq |=> $stable(faultCode_q))
    else $error("code changed");
  active_flag_a: assert property (faultActive == (faultCode_q != 16'h0))
    else $error("flag wrong");
  code_range_a: assert property (
    faultActive |-> faultCode_q inside {[`CODE_NOHOME:`CODE_PLANFAIL]}) else $error("bad code");
  plan_fail_a: assert property (planFail && !faultActive |=> faultActive)
    else $error("no plan fault");
  abs_move_a: assert property (absMoveTrig && !homingDone && !faultActive |=> faultActive)
    else $error("no homing fault");
  reset_clean_a: assert property ($rose(nrst) |-> !faultActive && !irq)
    else $error("not clean");
endmodule // servo_fault_checker

bind servo_motion_fault_monitor servo_fault_checker i_chk (
  .ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .absMoveTrig, .homingDone, .planFail, .faultCode_q, .faultActive, .irq);

/* verification/motor_model.sv */
// motor, encoder and limit switch model
`timescale 1ns/1ps
module motor_model (
  // setpoints
  input  wire               ref_clk,
  input  wire signed [31:0] spdSet,
  input  wire signed [31:0] posSet,
  input  wire [15:0]        curSet,
  input  wire [1:0]         limSet,
  // feedback
  output reg  signed [31:0] speedAct,
  output reg  signed [31:0] posAct,
  output reg  signed [31:0] userPos,
  output reg  [15:0]        currentPct,
  output reg                fwdLimitPin,
  output reg                revLimitPin
);
  // feedback lags setpoints by one cycle
  always @(posedge ref_clk) begin
    speedAct    <= spdSet;
    posAct      <= posSet;
    userPos     <= posSet;
    currentPct  <= curSet;
    fwdLimitPin <= limSet[1];
    revLimitPin <= limSet[0];
  end
endmodule // motor_model

/* verification/servo_motion_fault_monitor_tb_top.sv */
// self-checking bench for the servo fault monitor
`timescale 1ns/1ps
`include "servo_fault_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module servo_motion_fault_monitor_tb_top;
  logic               ref_clk = 0, nrst = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]         wb_adr_i = 0;
  logic [3:0]         wb_sel_i = 4'hf;
  logic [31:0]        wb_dat_i = 0, wb_dat_o, rdData, maskV = 32'h2aa;
  logic               wb_ack_o, absMoveTrig = 0, homingDone = 0, planFail = 0;
  logic signed [31:0] speedAct, posCmd = 0, posAct, userPos, spdSet = 0, posSet = 0;
  logic [15:0]        currentPct, curSet = 0, faultCode_q, code;
  logic [1:0]         limSet = 0;
  logic               fwdLimitPin, revLimitPin, faultActive, irq;
  int                 n_errors = 0, num_checks = 0, seed = 59;

  always #5 ref_clk = ~ref_clk;

  servo_motion_fault_monitor #(.NTERM(8), .OVL_CYCLES(32'd20)) i_dut (
    .ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .speedAct, .posCmd, .posAct, .userPos, .currentPct, .absMoveTrig,
    .homingDone, .planFail, .fwdLimitPin, .revLimitPin, .faultCode_q, .faultActive, .irq);
  motor_model i_motor (.ref_clk, .spdSet, .posSet, .curSet, .limSet, .speedAct, .posAct,
    .userPos, .currentPct, .fwdLimitPin, .revLimitPin);

  task automatic wb(input bit we, input [7:0] a, input [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i} <= 2'b11;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      close_out();
    end else begin
      rdData = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
    end
  endtask

  function automatic logic [15:0] codeOf(input int f);
    return 16'(`CODE_NOHOME + (f < 7 ? f : f < 9 ? 7 : f < 11 ? 8 : 9));
  endfunction

  // raise (on) or just avoid (off) one fault condition
  task automatic setup(input int f, input bit on);
    case (f)
      0: wb(1, on ? `ADR_CTRL : `ADR_MAP0, on ? 32'h1 : 32'h22);
      1: wb(1, `ADR_MAP0 + 8, on ? 32'h5 : 32'h6);
      2: spdSet <= on ? 3601 : 3600;
      3: posCmd <= on ? 65537 : 65536;
      4: wb(1, on ? `ADR_CTRL : `ADR_MAP0 + 12, on ? 32'h2 : 32'h28);
      5: absMoveTrig <= on;
      6: begin
        curSet <= on ? 101 : 100;
        repeat (25) @(posedge ref_clk);
      end
      7: begin
        wb(1, `ADR_LIMSEL, 32'h1);
        wb(1, `ADR_SOFTLO, -32'sd100);
        posSet <= -200;
        posCmd <= -200;
        spdSet <= on ? -5 : 5;
      end
      8: begin
        wb(1, `ADR_SOFTHI, 32'd100);
        posSet <= 200;
        posCmd <= 200;
        spdSet <= on ? 5 : -5;
      end
      9: begin
        wb(1, `ADR_LIMSEL, 32'h2);
        limSet <= on ? 2'b01 : 2'b10;
      end
      10: begin
        limSet <= on ? 2'b10 : 2'b01;
        repeat (4) @(posedge ref_clk);
        spdSet <= 5;
      end
      default: planFail <= on;
    endcase
  endtask

  task automatic clear_all;
    wb(1, `ADR_STATUS, 32'h3ff);
    wb(1, `ADR_CTRL, 32'h4);
    wb(0, `ADR_STATUS, 0);
    `CHK(rdData, 32'h0)
    `CHK(faultCode_q, 16'h0)
    `CHK(irq, 1'b0)
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_errors++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1;
    @(posedge ref_clk);
    `CHK(faultCode_q, 16'h0)
    wb(0, `ADR_RATED, 0);
    `CHK(rdData, {16'h0, `RST_RATED})
    wb(0, 8'h3c, 0);
    `CHK(rdData, 32'h0)
    wb(1, `ADR_MASK, maskV);
    wb_sel_i <= 4'h3;
    wb(1, `ADR_MASK, 32'h155);
    wb_sel_i <= 4'hf;
    wb(0, `ADR_MASK, 0);
    `CHK(rdData, maskV)
    wb(1, `ADR_UNLOCK, {16'h0, `UNLOCK_KEY});
    wb(1, `ADR_ZOFFS, 32'h0);
    wb(0, `ADR_ZOFFS, 0);
    `CHK(rdData, 32'h0)
    wb(0, `ADR_UNLOCK, 0);
    `CHK(rdData, 32'h0)
    $display("register test done");
    homingDone <= 1;
    repeat (300) begin
      @(posedge ref_clk);
      spdSet <= $random(seed) % 3601;
      curSet <= 16'($unsigned($random(seed)) % 101);
      limSet <= 2'($random(seed));
      absMoveTrig <= 1'($random(seed));
    end
    `CHK(faultCode_q, 16'h0)
    absMoveTrig <= 0;
    homingDone <= 0;
    limSet <= 0;
    curSet <= 0;
    $display("random test done");
    wb(1, `ADR_MAP0 + 4, 32'h5);
    for (int f = 0; f < 12; f++) begin
      setup(f, 1);
      repeat (6) @(posedge ref_clk);
      code = codeOf(f);
      `CHK(faultCode_q, code)
      `CHK(faultActive, 1'b1)
      `CHK(irq, maskV[code - 16'd200])
      wb(0, `ADR_STATUS, 0);
      `CHK(rdData, 32'h1 << (code - 16'd200))
      setup(f, 0);
      repeat (6) @(posedge ref_clk);
      clear_all();
      $display("fault case %0d done", f);
    end
    close_out();
  end
endmodule // servo_motion_fault_monitor_tb_top
